// ===== scsw_asserts.sv
// Port-level checks of the scan sequencer.
`timescale 1ns/1ps
module scsw_asserts
  import scsw_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Watched ports.
  input wire logic [7:0] in_pins,
  input wire logic [7:0] in_bits,
  input wire logic [3:0] rmaster_units,
  input wire scsw_phase_e phase,
  input wire logic cycle_start,
  input wire logic rmaster_service,
  input wire logic halted,
  input wire logic [7:0] fatal_error_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // A phase that has just been left.
  sequence s_left(scsw_phase_e p);
    phase == p ##1 phase != p;
  endsequence
  // Order and length of phases, new-cycle pulses, input latch and halt state.
  a_init_once: assert property (phase != SCSW_INIT |=> phase != SCSW_INIT)
    else $error("init reentered");
  a_io_next: assert property (s_left(SCSW_IO) |-> phase inside {SCSW_HOST, SCSW_HALT})
    else $error("io not followed by host");
  a_prog_next: assert property (s_left(SCSW_PROG) |-> phase inside {SCSW_CALC, SCSW_HALT})
    else $error("prog not followed by calc");
  a_calc_next: assert property (s_left(SCSW_CALC) |-> phase inside {SCSW_IO, SCSW_HALT})
    else $error("calc not followed by io");
  a_start_io: assert property (cycle_start |=> phase == SCSW_IO)
    else $error("start without io");
  a_oversee_len: assert property ($rose(phase == SCSW_OVERSEE) |->
    ##130 phase inside {SCSW_OVERSEE, SCSW_HALT} ##[1:16] phase != SCSW_OVERSEE)
    else $error("oversee length wrong");
  a_rm_once: assert property (rmaster_service == (cycle_start && rmaster_units != 4'h0))
    else $error("remote service pulse wrong");
  a_in_latch: assert property (cycle_start |=> in_bits == $past(in_pins))
    else $error("inputs not latched");
  a_halt_code: assert property (halted |=> halted && phase == SCSW_HALT && fatal_error_code == 8'h9F)
    else $error("halt state wrong");
endmodule : scsw_asserts

// ===== scsw_params.svh
// Constants for the scan-cycle sequencer and cycle watchdog.
`ifndef SCSW_PARAMS_SVH
`define SCSW_PARAMS_SVH
`define SCSW_CLK_HZ 25000000
`define SCSW_TICK_CYC (`SCSW_CLK_HZ / 10000)
`define SCSW_STARTUP_TICKS 16'h000A
`define SCSW_OVERSEE_US 3500
`define SCSW_IN_WORD_US 70
`define SCSW_OUT_WORD_US 40
`define SCSW_RMASTER_US 1300
`define SCSW_RSLAVE_US 200
`define SCSW_HOST_MAX_US 8000
`define SCSW_PERIPH_US 800
`define SCSW_PERIPH_THR_MS 13
`define SCSW_NET_UNIT_US 1500
`define SCSW_NET_MAX_US 10000
`define SCSW_TIMH_MS 10
`define SCSW_CP002_MS 20
`define SCSW_CTERR_MS 100
`define SCSW_CP02_MS 200
`define SCSW_ABS_MS 6500
`define SCSW_FATAL_CODE 8'h9F
`define SCSW_WDT_RESET_MS 16'h0082
`endif

// ===== scsw_partner.sv
// Far-side model: input pins and early-end strobes.
`timescale 1ns/1ps
module scsw_partner
  import scsw_pkg::*;
(
  // Clock and status seen.
  input wire logic clk,
  input wire scsw_phase_e phase,
  input wire logic stall,
  // Pins and strobes driven.
  output logic [7:0] in_pins,
  output logic host_done,
  output logic net_done,
  output logic prog_done
);
  // Links answer at once; the program ends unless told to stall.
  assign host_done = phase == SCSW_HOST;
  assign net_done = phase == SCSW_NET;
  assign prog_done = (phase == SCSW_PROG) && !stall;
  // Pins change on every clock so that a stale latch shows.
  initial in_pins = 8'h00;
  always @(posedge clk) in_pins <= in_pins + 8'h01;
endmodule : scsw_partner

// ===== scsw_pkg.sv
// Types for the scan-cycle sequencer and cycle watchdog.
package scsw_pkg;
  typedef enum logic [3:0] {
    SCSW_INIT, SCSW_IO, SCSW_HOST, SCSW_PERIPH, SCSW_NET, SCSW_OVERSEE, SCSW_PROG,
    SCSW_CALC, SCSW_HALT
  } scsw_phase_e;
  // Cycle statistics kept in the auxiliary area words.
  typedef struct packed {
    logic [15:0] max_ms;
    logic [15:0] cur_ms;
  } scsw_aux_s;
  // Long-cycle warning flags.
  typedef struct packed {
    logic timh_inaccurate;
    logic pulse_002_bad;
    logic cycle_timer_error;
    logic pulse_02_bad;
  } scsw_warn_s;
endpackage : scsw_pkg

// ===== scsw_sequencer.sv
// Scan-cycle phase sequencer with cycle-time watchdog.
`timescale 1ns/1ps
`include "scsw_params.svh"
module scsw_sequencer
  import scsw_pkg::*;
#(
  parameter int TICK_CYC = `SCSW_TICK_CYC,
  parameter int IN_W = 8,
  parameter int OUT_W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Configuration of mounted units.
  input wire logic [7:0] in_words,
  input wire logic [7:0] out_words,
  input wire logic [3:0] rmaster_units,
  input wire logic [5:0] rslave_units,
  input wire logic [3:0] host_units,
  input wire logic periph_mounted,
  input wire logic [3:0] net_units,
  // Early phase end strobes from serviced units and the program.
  input wire logic host_done,
  input wire logic net_done,
  input wire logic prog_done,
  // Watchdog and minimum cycle settings from the program.
  input wire logic watchdog_extend_instruction,
  input wire logic [15:0] wdt_ext_ms,
  input wire logic min_cycle_en,
  input wire logic [15:0] min_cycle_ms,
  // Physical I/O.
  input wire logic [IN_W-1:0] in_pins,
  input wire logic [OUT_W-1:0] out_bits,
  output logic [IN_W-1:0] in_bits,
  output logic [OUT_W-1:0] out_pins,
  // Status.
  output scsw_phase_e phase,
  output logic cycle_start,
  output logic rmaster_service,
  output scsw_aux_s auxiliary_area_word,
  output scsw_warn_s warn,
  output logic halted,
  output logic [7:0] fatal_error_code
);
  // Ticks of 0.1 ms per millisecond of cycle time.
  // All budgets and the cycle timer count these ticks, so a cycle time is
  // resolved to a tenth of a millisecond and reported in whole milliseconds.
  localparam int TPM = 10;
  // Width of the prescaler; TICK_CYC must be at least 2 for it to be legal.
  localparam int TICK_W = $clog2(TICK_CYC);

  // Prescaler to 0.1 ms ticks.
  // It runs free after reset, so the first tick of a phase may come after a
  // fraction of a tick; every phase budget is therefore good to one tick.
  logic [TICK_W-1:0] pre;
  wire tick = (pre == TICK_W'(TICK_CYC - 1));
  always_ff @(posedge clk) begin
    if (!resetn || tick) pre <= '0;
    else pre <= pre + 1'b1;
  end

  // Timing state of the scan.
  // The phase counter holds the ticks spent in the phase now running, the
  // cycle timer the ticks since the scan last entered I/O refresh, and the
  // last cycle time feeds the peripheral budget of the next cycle.
  // The watchdog set value is kept in milliseconds, as the program gives it.
  logic [19:0] ph_ticks;
  logic [19:0] cyc_ticks;
  logic [15:0] wdt_ms;
  logic [15:0] last_ms;
  logic [19:0] budget;

  // Phase budgets in 0.1 ms ticks.
  // Microsecond sums are cut to whole ticks, which rounds each budget down.
  // A configuration with no units gives a zero budget, and such a phase is
  // passed in a single clock rather than waiting for a tick.
  wire [19:0] io_b = 20'((in_words * `SCSW_IN_WORD_US + out_words * `SCSW_OUT_WORD_US
    + rmaster_units * `SCSW_RMASTER_US + rslave_units * `SCSW_RSLAVE_US) / 100);
  wire [19:0] host_b = 20'(host_units * (`SCSW_HOST_MAX_US / 100));
  wire [19:0] per_b = !periph_mounted ? 20'h00000 :
    (last_ms <= 16'(`SCSW_PERIPH_THR_MS)) ? 20'(`SCSW_PERIPH_US / 100) :
    20'((last_ms * 6) / 10);
  wire [19:0] net_b = 20'(net_units * (`SCSW_NET_UNIT_US / 100)
    + (net_units != 4'h0 ? `SCSW_NET_MAX_US / 100 : 0));

  // Cycle time in milliseconds and the limits it is held against.
  // The overrun tests are live on every clock, so a cycle that runs long
  // is stopped in whichever phase it happens to be in.
  wire [19:0] cyc_ms = 20'(cyc_ticks / TPM);
  wire over_wdt = cyc_ms > 20'(wdt_ms);
  wire over_abs = cyc_ms >= 20'(`SCSW_ABS_MS);
  wire ph_end = tick && (ph_ticks + 20'h00001 >= budget);
  wire min_ok = !min_cycle_en || (cyc_ms >= 20'(min_cycle_ms));

  // Budget of the phase now running; early strobes end host, net and program.
  // Program execution and cycle calculation have no budget of their own: the
  // first ends on its strobe and the second on the minimum-cycle test.
  always_comb begin
    case (phase)
      SCSW_INIT: budget = 20'(`SCSW_STARTUP_TICKS);
      SCSW_IO: budget = io_b;
      SCSW_HOST: budget = host_b;
      SCSW_PERIPH: budget = per_b;
      SCSW_NET: budget = net_b;
      SCSW_OVERSEE: budget = 20'(`SCSW_OVERSEE_US / 100);
      default: budget = 20'h00000;
    endcase
  end

  // Link phases end on the unit's done strobe, on a zero budget, or when the
  // budget runs out, whichever comes first.
  wire host_fin = host_done || host_b == 20'h00000 || ph_end;
  wire net_fin = net_done || net_b == 20'h00000 || ph_end;

  // Next phase in fixed order.
  // Start-up is left once and never re-entered, since no branch leads back
  // to it. An overrun in any scan phase sends the machine to the halt state,
  // which only a reset leaves. The overrun test comes last so that it wins
  // over any ordinary phase change in the same clock.
  scsw_phase_e next_phase;
  always_comb begin
    next_phase = phase;
    case (phase)
      SCSW_INIT: if (ph_end) next_phase = SCSW_IO;
      SCSW_IO: if (ph_end || io_b == 20'h00000) next_phase = SCSW_HOST;
      SCSW_HOST: if (host_fin) next_phase = SCSW_PERIPH;
      SCSW_PERIPH: if (ph_end || per_b == 20'h00000) next_phase = SCSW_NET;
      SCSW_NET: if (net_fin) next_phase = SCSW_OVERSEE;
      SCSW_OVERSEE: if (ph_end) next_phase = SCSW_PROG;
      SCSW_PROG: if (prog_done) next_phase = SCSW_CALC;
      SCSW_CALC: if (min_ok) next_phase = SCSW_IO;
      default: next_phase = SCSW_HALT;
    endcase
    if (phase != SCSW_INIT && (over_wdt || over_abs)) next_phase = SCSW_HALT;
  end

  // End of one scan: the calculation is done and I/O refresh is next.
  // This is the single boundary at which a cycle ends and the next begins.
  wire leaving_calc = phase == SCSW_CALC && next_phase == SCSW_IO;

  // Phase register and per-phase tick counter.
  // The tick counter clears on every change of phase, so a phase entered
  // between two ticks counts its first, partial tick as a whole one.
  always_ff @(posedge clk) begin
    if (!resetn) phase <= SCSW_INIT;
    else phase <= next_phase;
  end
  always_ff @(posedge clk) begin
    if (!resetn || next_phase != phase) ph_ticks <= '0;
    else if (tick) ph_ticks <= ph_ticks + 20'h00001;
  end

  // Cycle timer restarts when the scan re-enters I/O refresh.
  // It is held at zero during start-up so that the start-up time never counts
  // against the watchdog, and it freezes at its top value and in halt so that
  // a stopped scan cannot wrap back below the limits. The stall of a minimum
  // cycle is counted, since it belongs to the cycle that it lengthens.
  always_ff @(posedge clk) begin
    if (!resetn || leaving_calc || phase == SCSW_INIT) cyc_ticks <= '0;
    else if (tick && phase != SCSW_HALT && cyc_ticks != 20'hFFFFF)
      cyc_ticks <= cyc_ticks + 20'h00001;
  end
  // Cycle start pulse, one clock wide, also marking the first scan after start-up.
  assign cycle_start = leaving_calc || (phase == SCSW_INIT && next_phase == SCSW_IO);

  // Watchdog set value, extended by the program.
  // The new value takes effect at once and is held until reset or the next extension; a value below
  // the time already spent in the running cycle stops the scan at once.
  always_ff @(posedge clk) begin
    if (!resetn) wdt_ms <= `SCSW_WDT_RESET_MS;
    else if (watchdog_extend_instruction) wdt_ms <= wdt_ext_ms;
  end

  // Cycle statistics and warnings, updated at each cycle calculation.
  // The current and last values follow every cycle, the maximum only grows,
  // and the cycle timer error flag stays set until reset. The other warnings
  // describe the cycle just ended and clear again after a short cycle.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      last_ms <= '0;
      auxiliary_area_word <= '0;
      warn <= '0;
    end else if (leaving_calc) begin
      last_ms <= cyc_ms[15:0];
      auxiliary_area_word.cur_ms <= cyc_ms[15:0];
      if (cyc_ms[15:0] > auxiliary_area_word.max_ms) auxiliary_area_word.max_ms <= cyc_ms[15:0];
      warn.timh_inaccurate <= cyc_ms >= 20'(`SCSW_TIMH_MS);
      warn.pulse_002_bad <= cyc_ms >= 20'(`SCSW_CP002_MS);
      warn.pulse_02_bad <= cyc_ms >= 20'(`SCSW_CP02_MS);
      if (cyc_ms >= 20'(`SCSW_CTERR_MS)) warn.cycle_timer_error <= 1'b1;
    end
  end

  // Halt and fatal code.
  // Both are set on the clock that enters the halt state and then held, so the
  // code remains readable however long the controller stays stopped.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      halted <= 1'b0;
      fatal_error_code <= 8'h00;
    end else if (next_phase == SCSW_HALT && !halted) begin
      halted <= 1'b1;
      fatal_error_code <= `SCSW_FATAL_CODE;
    end
  end

  // I/O refresh: latch inputs and drive outputs on entering the phase.
  // Inputs and outputs change once per cycle only, so a pin pulse shorter than
  // a cycle can be missed. Remote masters are serviced by the same single
  // pulse, which is why slave data may go a cycle without refresh when the
  // remote transfer outlasts the scan.
  wire io_entry = phase != SCSW_IO && next_phase == SCSW_IO;
  // Remote master service request, raised only when masters are mounted.
  assign rmaster_service = io_entry && rmaster_units != 4'h0;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      in_bits <= '0;
      out_pins <= '0;
    end else if (io_entry) begin
      in_bits <= in_pins;
      out_pins <= out_bits;
    end
  end
endmodule : scsw_sequencer

// ===== tb_top.sv
// Self-checking bench for the scan sequencer.
`timescale 1ns/1ps
module tb_top
  import scsw_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, stall = 1'b0, periph_mounted = 1'b1;
  logic watchdog_extend_instruction = 1'b0, min_cycle_en = 1'b0;
  logic [15:0] wdt_ext_ms = 16'h0008, min_cycle_ms = 16'h0064;
  logic [3:0] rmaster_units = 4'h1, host_units = 4'h1;
  logic [7:0] out_bits = 8'hA5, in_pins, in_bits, out_pins, fatal_error_code;
  logic host_done, net_done, prog_done, cycle_start, rmaster_service, halted;
  scsw_phase_e phase;
  scsw_aux_s auxiliary_area_word;
  scsw_warn_s warn;
  int n_mismatch = 0, checks_done = 0;
  always #20 clk = ~clk;
  // Design and far side.
  scsw_sequencer #(.TICK_CYC(4)) DUT (.clk, .resetn, .in_words(8'h02), .out_words(8'h01),
    .rmaster_units, .rslave_units(6'h02), .host_units, .periph_mounted, .net_units(4'h1),
    .host_done, .net_done, .prog_done, .watchdog_extend_instruction, .wdt_ext_ms, .min_cycle_en,
    .min_cycle_ms, .in_pins, .out_bits, .in_bits, .out_pins, .phase, .cycle_start,
    .rmaster_service, .auxiliary_area_word, .warn, .halted, .fatal_error_code);
  scsw_partner far (.clk, .phase, .stall, .in_pins, .host_done, .net_done, .prog_done);
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // Waits for the next cycle start and returns the clocks waited.
  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n > 9000) begin
        n_mismatch++;
        wrap_up();
      end
    end while (cycle_start !== 1'b1);
  endtask : wait_start
  // Records the phases of one whole cycle.
  task automatic s_order();
    scsw_phase_e seq[$];
    scsw_phase_e want[7] = '{SCSW_IO, SCSW_HOST, SCSW_PERIPH, SCSW_NET, SCSW_OVERSEE,
      SCSW_PROG, SCSW_CALC};
    int n;
    int n_rm;
    n_rm = 0;
    wait_start(n);
    wait_start(n);
    for (int k = 0; k < 9000 && (k == 0 || cycle_start !== 1'b1); k++) begin
      @(posedge clk);
      #1;
      if (seq.size() == 0 || seq[$] !== phase) seq.push_back(phase);
      if (rmaster_service === 1'b1) n_rm++;
    end
    for (int i = 0; i < 7; i++) chk("phase", 32'(seq[i]), 32'(want[i]));
    chk("rm_service", 32'(n_rm), 32'h00000001);
    chk("out_pins", 32'(out_pins), 32'h000000A5);
  endtask : s_order
  // Minimum cycle of 100 ms and the long-cycle flags.
  task automatic s_min();
    int n;
    min_cycle_en = 1'b1;
    // A zero host budget is passed in one clock; new outputs must be refreshed.
    host_units = 4'h0;
    out_bits = 8'h5A;
    wait_start(n);
    wait_start(n);
    repeat (2) @(posedge clk);
    #1;
    chk("cycle", 32'(n >= 4000), 32'h1);
    chk("out_pins", 32'(out_pins), 32'h0000005A);
    chk("cur_ms", 32'(auxiliary_area_word.cur_ms >= 16'h0064), 32'h1);
    chk("max_ms", 32'(auxiliary_area_word.max_ms >= 16'h0064), 32'h1);
    chk("warn", 32'(warn), 32'h0000000E);
    min_cycle_en = 1'b0;
  endtask : s_min
  // Watchdog cut to 8 ms, then a program that never ends.
  task automatic s_halt();
    int k;
    @(posedge clk);
    #1 watchdog_extend_instruction = 1'b1;
    @(posedge clk);
    #1 watchdog_extend_instruction = 1'b0;
    stall = 1'b1;
    // The running cycle already holds more than 8 ms of budgets, so it halts.
    for (k = 0; k < 9000 && halted !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("wd time", 32'(k >= 320 && k <= 400), 32'h1);
    chk("code", 32'(fatal_error_code), 32'h0000009F);
    chk("halted", 32'(halted), 32'h1);
  endtask : s_halt
  initial begin
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    s_order();
    s_min();
    s_halt();
    wrap_up();
  end
endmodule : tb_top
bind scsw_sequencer scsw_asserts chk_i (.clk, .resetn, .in_pins, .in_bits, .rmaster_units,
  .phase, .cycle_start, .rmaster_service, .halted, .fatal_error_code);
